//--- common/dms_pkg.sv
// dms_pkg: constants and types for the data memory sector decoder
// assumes one system clock domain and a CPU issuing single-cycle accesses
package dms_pkg;
  localparam int DATA_W = 8;
  localparam int SECT_W = 5;
  localparam int OFS_W = 8;
  localparam int NUM_GP_SECT = 18;
  localparam int GP_BYTES = 2304;
  localparam int GP_ADDR_W = 12;
  localparam int LCD_BYTES = 32;
  localparam logic [SECT_W-1:0] SECT_ZERO = 5'h00;
  localparam logic [SECT_W-1:0] SECT_SFR_HI = 5'h01;
  localparam logic [SECT_W-1:0] SECT_LCD = 5'h04;
  localparam logic [SECT_W-1:0] SECT_GP_LAST = 5'h11;
  localparam logic [OFS_W-1:0] OFS_BASE = 8'h00;
  localparam logic [OFS_W-1:0] OFS_GP_LO = 8'h80;
  localparam logic [OFS_W-1:0] OFS_LCD_HI = 8'h1F;
  localparam logic [OFS_W-1:0] OFS_SFR_HI = 8'h7F;
  localparam logic [OFS_W-1:0] OFS_POINTER0 = 8'h01;
  localparam logic [OFS_W-1:0] OFS_PORT_ONE = 8'h02;
  localparam logic [OFS_W-1:0] OFS_PTR1_OFS = 8'h03;
  localparam logic [OFS_W-1:0] OFS_PTR1_SEC = 8'h04;
  localparam logic [OFS_W-1:0] OFS_PORT_TWO = 8'h0C;
  localparam logic [OFS_W-1:0] OFS_PTR2_OFS = 8'h0D;
  localparam logic [OFS_W-1:0] OFS_PTR2_SEC = 8'h0E;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] UNUSED_BYTE = 8'h00;
  typedef enum logic [1:0] {
    DMS_OP_BYTE = 2'b00,
    DMS_OP_BSET = 2'b01,
    DMS_OP_BCLR = 2'b10
  } dms_op_t;
  typedef enum logic [1:0] {
    DMS_MODE_STD = 2'b00,
    DMS_MODE_EXT = 2'b01
  } dms_mode_t;
  typedef enum logic [2:0] {
    DMS_TGT_NONE = 3'b000,
    DMS_TGT_GP = 3'b001,
    DMS_TGT_LCD = 3'b010,
    DMS_TGT_PTR = 3'b011,
    DMS_TGT_SFR = 3'b100
  } dms_tgt_t;
endpackage

//--- common/dms_mem_if.sv
// dms_mem_if: port bundle between the decoder and its general RAM array
// assumes a single clock and a synchronous one-cycle read
`timescale 1ns/100ps
interface dms_mem_if #(parameter int AW = 12, parameter int DW = 8);
  logic wrEn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wrData;
  logic [DW-1:0] rdData;
  modport ctrl (output wrEn, output addr, output wrData, input rdData);
  modport mem (input wrEn, input addr, input wrData, output rdData);
endinterface

//--- rtl/dms_gp_ram.sv
// dms_gp_ram: general purpose byte array with registered read data
// assumes address held stable during access; no reset on contents
`timescale 1ns/100ps
module dms_gp_ram #(
  parameter int DEPTH = 2304
) (
  input wire logic clk_sys,
  dms_mem_if.mem port
);
  logic [7:0] memArr [DEPTH];
  logic [7:0] rdData_r;
  initial begin
    if (DEPTH < 1 || DEPTH > 4096) $error("dms_gp_ram depth out of range");
  end
  always_ff @(posedge clk_sys) begin
    if (port.wrEn) begin
      memArr[port.addr] <= port.wrData;
    end
    rdData_r <= memArr[port.addr];
  end
  assign port.rdData = rdData_r;
endmodule

//--- rtl/dms_lcd_mem.sv
// dms_lcd_mem: display byte store whose bits drive the segment lines
// assumes one clock; contents clear at reset
`timescale 1ns/100ps
module dms_lcd_mem
  import dms_pkg::*;
#(
  parameter int BYTES = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic [BYTES*8-1:0] segData
);
  logic [7:0] cell_r [BYTES];
  initial begin
    if (BYTES != 32) $error("dms_lcd_mem supports 32 bytes only");
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BYTES; i++) cell_r[i] <= RESET_BYTE;
    end else if (wrEn) begin
      cell_r[addr] <= wrData;
    end
  end
  assign rdData = cell_r[addr];
  for (genvar g = 0; g < BYTES; g++) begin : gSeg
    assign segData[g*8 +: 8] = cell_r[g];
  end
endmodule

//--- rtl/dms_decoder.sv
// dms_decoder: maps CPU data accesses onto the sectored data space
// assumes the CPU holds a request one cycle and samples rdData one cycle later
// Overview of operation
// - every location is one byte; all transfers move eight bits
// - offsets inside each sector are decoded from 00H upward
// - general RAM sits at 80H-FFH of sectors 0 to 17, read/write
// - sector 4 offsets 00H-1FH hold display bytes driving segment outputs
// - no bank pointer selects data sectors; program bank select is ignored
// - indirect access takes sector from pointer high byte, offset from low byte
// - extended instructions give 13-bit address: sector high, offset low
// - standard direct addressing reaches sector 0 only
// - unimplemented special locations read as 00H
// - protected special registers ignore writes; others read and write
// - bit set/clear on a byte keeps the other seven bits
`timescale 1ns/100ps
module dms_decoder
  import dms_pkg::*;
#(
  parameter int GP_SECTORS = 18,
  parameter int SFR_SLOTS = 256
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire dms_pkg::dms_mode_t reqMode,
  input wire dms_pkg::dms_op_t reqOp,
  input wire logic [2:0] reqBit,
  input wire logic [12:0] reqAddr,
  input wire logic [7:0] reqWrData,
  input wire logic [7:0] programBankSelect,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [255:0] lcdSegData,
  output logic [7:0] sfrWrData,
  output logic [7:0] sfrAddr,
  output logic sfrSector,
  output logic sfrWrite,
  input wire logic [7:0] sfrRdData,
  input wire logic sfrImplemented,
  input wire logic sfrProtected
);
  import dms_pkg::*;

  initial begin
    if (GP_SECTORS != NUM_GP_SECT) $error("dms_decoder supports 18 RAM sectors only");
    if (SFR_SLOTS != 256) $error("dms_decoder supports 256 special slots only");
  end

  logic [7:0] pointer0_r;
  logic [7:0] ptrOneOfs_r;
  logic [7:0] ptrOneSec_r;
  logic [7:0] ptrTwoOfs_r;
  logic [7:0] ptrTwoSec_r;

  // first-stage address: standard mode forces sector 0, extended uses high bits
  wire [SECT_W-1:0] dirSect = (reqMode == DMS_MODE_EXT) ? reqAddr[12:8] : SECT_ZERO;
  wire [OFS_W-1:0] dirOfs = reqAddr[7:0];
  wire hitPortOne = (dirSect == SECT_ZERO) && (dirOfs == OFS_PORT_ONE);
  wire hitPortTwo = (dirSect == SECT_ZERO) && (dirOfs == OFS_PORT_TWO);
  // redirect through pointer pairs; the bank select input plays no part
  wire [SECT_W-1:0] effSect = hitPortOne ? ptrOneSec_r[SECT_W-1:0] :
                             hitPortTwo ? ptrTwoSec_r[SECT_W-1:0] : dirSect;
  wire [OFS_W-1:0] effOfs = hitPortOne ? ptrOneOfs_r :
                            hitPortTwo ? ptrTwoOfs_r : dirOfs;
  wire sectHiZero = hitPortOne ? (ptrOneSec_r[7:SECT_W] == 3'h0) :
                    hitPortTwo ? (ptrTwoSec_r[7:SECT_W] == 3'h0) : 1'b1;

  function automatic logic isPtrReg(input logic [7:0] ofs);
    isPtrReg = (ofs == OFS_POINTER0) || (ofs == OFS_PTR1_OFS) || (ofs == OFS_PTR1_SEC) ||
               (ofs == OFS_PTR2_OFS) || (ofs == OFS_PTR2_SEC);
  endfunction

  // set or clear one bit of a byte, other seven kept
  function automatic logic [7:0] applyBit(input logic [7:0] oldVal, input logic [7:0] mask,
                                          input logic setBit);
    applyBit = setBit ? (oldVal | mask) : (oldVal & ~mask);
  endfunction

  // pointer register picked by its sector 0 offset; bank packs the five low to high
  function automatic logic [7:0] pickPtr(input logic [7:0] ofs, input logic [39:0] bank);
    pickPtr = (ofs == OFS_POINTER0) ? bank[7:0] :
              (ofs == OFS_PTR1_OFS) ? bank[15:8] :
              (ofs == OFS_PTR1_SEC) ? bank[23:16] :
              (ofs == OFS_PTR2_OFS) ? bank[31:24] : bank[39:32];
  endfunction

  dms_tgt_t tgt;
  always_comb begin
    tgt = DMS_TGT_NONE;
    if (!sectHiZero) begin
      tgt = DMS_TGT_NONE;
    end else if (effOfs >= OFS_GP_LO && effSect <= SECT_GP_LAST) begin
      tgt = DMS_TGT_GP;
    end else if (effSect == SECT_LCD && effOfs <= OFS_LCD_HI) begin
      tgt = DMS_TGT_LCD;
    end else if (effSect == SECT_ZERO && isPtrReg(effOfs)) begin
      tgt = DMS_TGT_PTR;
    end else if ((effSect == SECT_ZERO || effSect == SECT_SFR_HI) && effOfs <= OFS_SFR_HI
                 && !(effSect == SECT_ZERO && (effOfs == OFS_PORT_ONE || effOfs == OFS_PORT_TWO))) begin
      tgt = DMS_TGT_SFR;
    end
  end

  // general RAM index: sector * 128 + (offset - 80H)
  wire [GP_ADDR_W-1:0] gpIndex = {effSect[4:0], effOfs[6:0]};

  dms_mem_if #(.AW(GP_ADDR_W), .DW(DATA_W)) gpBus ();

  // bit operations need the old byte: read cycle then write cycle
  logic pending_r;
  logic [7:0] pendMask_r;
  logic pendSet_r;
  dms_tgt_t pendTgt_r;
  logic [GP_ADDR_W-1:0] pendIdx_r;
  logic [4:0] pendLcd_r;
  logic [7:0] pendSfr_r;
  logic pendSfrSec_r;
  logic [7:0] lcdRd;

  wire bitOp = reqValid && reqWrite && (reqOp != DMS_OP_BYTE);
  wire byteWr = reqValid && reqWrite && (reqOp == DMS_OP_BYTE) && !pending_r;
  wire [7:0] oldByte = (pendTgt_r == DMS_TGT_GP) ? gpBus.rdData :
                       (pendTgt_r == DMS_TGT_LCD) ? lcdRd : sfrRdData;
  wire [7:0] bitResult = applyBit(oldByte, pendMask_r, pendSet_r);
  wire bitWr = pending_r;
  wire [7:0] wrByte = bitWr ? bitResult : reqWrData;

  assign gpBus.addr = bitWr ? pendIdx_r : gpIndex;
  assign gpBus.wrData = wrByte;
  assign gpBus.wrEn = bitWr ? (pendTgt_r == DMS_TGT_GP) : (byteWr && tgt == DMS_TGT_GP);

  dms_gp_ram #(.DEPTH(GP_BYTES)) uGpRam (
    .clk_sys(clk_sys),
    .port(gpBus.mem)
  );

  wire [4:0] lcdAddr = bitWr ? pendLcd_r : effOfs[4:0];
  wire lcdWr = bitWr ? (pendTgt_r == DMS_TGT_LCD) : (byteWr && tgt == DMS_TGT_LCD);

  dms_lcd_mem #(.BYTES(LCD_BYTES)) uLcd (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wrEn(lcdWr),
    .addr(lcdAddr),
    .wrData(wrByte),
    .rdData(lcdRd),
    .segData(lcdSegData)
  );

  // special register side: protected or unused slots never see a write
  assign sfrAddr = bitWr ? pendSfr_r : effOfs;
  assign sfrSector = bitWr ? pendSfrSec_r : effSect[0];
  assign sfrWrData = wrByte;
  assign sfrWrite = (bitWr ? (pendTgt_r == DMS_TGT_SFR) : (byteWr && tgt == DMS_TGT_SFR))
                    && sfrImplemented && !sfrProtected;

  wire ptrWr = byteWr && tgt == DMS_TGT_PTR;
  wire ptrBitWr = bitWr && pendTgt_r == DMS_TGT_PTR;
  wire [39:0] ptrBank = {ptrTwoSec_r, ptrTwoOfs_r, ptrOneSec_r, ptrOneOfs_r, pointer0_r};
  wire [7:0] ptrSel = pickPtr(effOfs, ptrBank);
  wire [7:0] ptrOld = pickPtr(pendSfr_r, ptrBank);
  wire [7:0] ptrBitVal = applyBit(ptrOld, pendMask_r, pendSet_r);
  wire [7:0] ptrWrOfs = ptrBitWr ? pendSfr_r : effOfs;
  wire [7:0] ptrWrVal = ptrBitWr ? ptrBitVal : reqWrData;
  wire ptrWrAny = ptrWr || ptrBitWr;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pointer0_r <= RESET_BYTE;
      ptrOneOfs_r <= RESET_BYTE;
      ptrOneSec_r <= RESET_BYTE;
      ptrTwoOfs_r <= RESET_BYTE;
      ptrTwoSec_r <= RESET_BYTE;
    end else if (ptrWrAny) begin
      if (ptrWrOfs == OFS_POINTER0) pointer0_r <= ptrWrVal;
      if (ptrWrOfs == OFS_PTR1_OFS) ptrOneOfs_r <= ptrWrVal;
      if (ptrWrOfs == OFS_PTR1_SEC) ptrOneSec_r <= ptrWrVal;
      if (ptrWrOfs == OFS_PTR2_OFS) ptrTwoOfs_r <= ptrWrVal;
      if (ptrWrOfs == OFS_PTR2_SEC) ptrTwoSec_r <= ptrWrVal;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pending_r <= 1'b0;
      pendMask_r <= RESET_BYTE;
      pendSet_r <= 1'b0;
      pendTgt_r <= DMS_TGT_NONE;
      pendIdx_r <= '0;
      pendLcd_r <= '0;
      pendSfr_r <= RESET_BYTE;
      pendSfrSec_r <= 1'b0;
    end else begin
      pending_r <= bitOp && !pending_r && tgt != DMS_TGT_NONE;
      pendMask_r <= 8'h01 << reqBit;
      pendSet_r <= (reqOp == DMS_OP_BSET);
      pendTgt_r <= tgt;
      pendIdx_r <= gpIndex;
      pendLcd_r <= effOfs[4:0];
      pendSfr_r <= effOfs;
      pendSfrSec_r <= effSect[0];
    end
  end

  // read path: target latched, data muxed one cycle after the request
  dms_tgt_t rdTgt_r;
  logic rdReq_r;
  logic [7:0] lcdRd_r;
  logic [7:0] sfrRd_r;
  logic [7:0] ptrRd_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdTgt_r <= DMS_TGT_NONE;
      rdReq_r <= 1'b0;
      lcdRd_r <= RESET_BYTE;
      sfrRd_r <= RESET_BYTE;
      ptrRd_r <= RESET_BYTE;
    end else begin
      rdReq_r <= reqValid && !reqWrite && !pending_r;
      rdTgt_r <= tgt;
      lcdRd_r <= lcdRd;
      sfrRd_r <= sfrImplemented ? sfrRdData : UNUSED_BYTE;
      ptrRd_r <= ptrSel;
    end
  end

  always_comb begin
    rdData = UNUSED_BYTE;
    case (rdTgt_r)
      DMS_TGT_GP: rdData = gpBus.rdData;
      DMS_TGT_LCD: rdData = lcdRd_r;
      DMS_TGT_SFR: rdData = sfrRd_r;
      DMS_TGT_PTR: rdData = ptrRd_r;
      default: rdData = UNUSED_BYTE;
    endcase
  end
  assign rdValid = rdReq_r;

  a_std_sector_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reqMode == DMS_MODE_STD && !hitPortOne && !hitPortTwo) |-> effSect == SECT_ZERO)
    else $error("standard access left sector 0");
  a_unused_reads_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reqValid && !reqWrite && !pending_r && tgt == DMS_TGT_NONE) |=> rdData == 8'h00)
    else $error("unused location read nonzero");
  a_protect_no_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfrProtected |-> !sfrWrite)
    else $error("write reached a protected register");
  a_ignore_unused_wr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (byteWr && tgt == DMS_TGT_NONE) |-> !gpBus.wrEn && !lcdWr && !sfrWrite && !ptrWrAny)
    else $error("write to unused location took effect");
  a_indirect_redirect: assert property (@(posedge clk_sys) disable iff (!nrst)
    (hitPortOne && ptrOneSec_r[7:5] == 3'h0) |-> effOfs == ptrOneOfs_r)
    else $error("indirect port one not redirected");
  a_bitop_keeps_rest: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bitWr && pendTgt_r == DMS_TGT_GP) |-> ((gpBus.wrData ^ gpBus.rdData) & ~pendMask_r) == 8'h00)
    else $error("bit operation disturbed other bits");
  a_gp_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    (byteWr && tgt == DMS_TGT_GP) ##1 (reqValid && !reqWrite && gpIndex == $past(gpIndex)
    && tgt == DMS_TGT_GP && !pending_r) |=> rdData == $past(reqWrData, 2))
    else $error("general RAM lost written byte");
  a_lcd_segments: assert property (@(posedge clk_sys) disable iff (!nrst)
    (lcdWr && !bitWr && effOfs[4:0] == 5'h00) |=> lcdSegData[7:0] == $past(reqWrData))
    else $error("display byte not on segments");

  a_gp_window: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tgt == DMS_TGT_GP) |-> effSect <= SECT_GP_LAST && effOfs >= OFS_GP_LO && sectHiZero)
    else $error("general RAM decoded outside its window");
  a_lcd_window: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tgt == DMS_TGT_LCD) |-> effSect == SECT_LCD && effOfs <= OFS_LCD_HI)
    else $error("display memory decoded outside its window");
  a_sfr_window: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tgt == DMS_TGT_SFR) |-> effOfs <= OFS_SFR_HI && effSect <= SECT_SFR_HI)
    else $error("special register decoded outside its window");
  a_ext_address: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reqMode == DMS_MODE_EXT && !hitPortOne && !hitPortTwo) |-> effSect == reqAddr[12:8] && effOfs == reqAddr[7:0])
    else $error("extended address split wrongly");
  a_port_two_redirect: assert property (@(posedge clk_sys) disable iff (!nrst)
    (hitPortTwo && ptrTwoSec_r[7:5] == 3'h0) |-> effSect == ptrTwoSec_r[4:0] && effOfs == ptrTwoOfs_r)
    else $error("indirect port two not redirected");
  a_ptr_bit_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bitWr && pendTgt_r == DMS_TGT_PTR) |-> ((ptrWrVal ^ ptrOld) & ~pendMask_r) == 8'h00)
    else $error("pointer bit operation disturbed other bits");
  a_absent_no_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    !sfrImplemented |-> !sfrWrite)
    else $error("write reached an absent special slot");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reqValid && !reqWrite && !pending_r) |=> rdValid)
    else $error("read answer missing one cycle later");
  a_bitop_one_slot: assert property (@(posedge clk_sys) disable iff (!nrst)
    pending_r |=> !pending_r)
    else $error("bit operation held more than one cycle");
  a_bank_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($changed(programBankSelect) && $stable(reqAddr) && $stable(reqMode) && $stable(ptrBank))
    |-> $stable(effSect) && $stable(effOfs))
    else $error("bank select moved a data access");
  a_write_one_target: assert property (@(posedge clk_sys) disable iff (!nrst)
    (byteWr || bitWr) |-> $onehot0({gpBus.wrEn, lcdWr, sfrWrite, ptrWrAny}))
    else $error("one write reached two targets");
endmodule

//--- bench/dms_sfr_model.sv
// dms_sfr_model: special register file that answers the decoder's sfr pins
// assumes sfr address pins settle combinationally before each rising edge
`timescale 1ns/100ps
module dms_sfr_model (
  input wire logic clk_sys,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrSector,
  input wire logic sfrWrite,
  output logic [7:0] sfrRdData,
  output logic sfrImplemented,
  output logic sfrProtected
);
  logic [7:0] regs [0:255];
  logic [7:0] junk = 8'h5A;
  wire logic [7:0] idx = {sfrSector, sfrAddr[6:0]};
  // slots 70H-7FH absent, 60H-6FH read-only
  assign sfrImplemented = sfrAddr[6:4] != 3'h7;
  assign sfrProtected = sfrAddr[6:4] == 3'h6;
  // an absent slot shows a changing pattern, never a clean zero
  assign sfrRdData = sfrImplemented ? regs[idx] : junk;
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'hA6;
    end
  end
  // stores on any strobe, so a strobe to a protected slot shows on read-back
  always @(posedge clk_sys) begin
    junk <= ~junk + 8'h01;
    if (sfrWrite) begin
      regs[idx] <= sfrWrData;
    end
  end
endmodule

//--- bench/tb_data_memory_sector_decoder.sv
// tb_data_memory_sector_decoder: self-checking bench for the sector decoder
// assumes the sfr model behind the special register pins
`timescale 1ns/100ps
module tb_data_memory_sector_decoder;
  import dms_pkg::*;
  typedef struct packed {logic w; dms_mode_t m; logic [12:0] a; logic [7:0] d;} dms_row_t;
  localparam dms_mode_t E = DMS_MODE_EXT;
  localparam dms_mode_t S = DMS_MODE_STD;
  localparam int NR = 41;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  dms_mode_t reqMode = DMS_MODE_STD;
  dms_op_t reqOp = DMS_OP_BYTE;
  logic [2:0] reqBit = 3'h0;
  logic [12:0] reqAddr = 13'h0000;
  logic [7:0] reqWrData = 8'h00;
  logic [7:0] programBankSelect = 8'h00;
  logic [7:0] rdData, sfrWrData, sfrAddr, sfrRdData;
  logic rdValid, sfrSector, sfrWrite, sfrImplemented, sfrProtected;
  logic [255:0] lcdSegData;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  dms_row_t rows [0:NR-1] = '{
    '{1'b1, E, 13'h0080, 8'hA5}, '{1'b1, E, 13'h1180, 8'h3C}, '{1'b1, E, 13'h01FF, 8'h5A},
    '{1'b0, E, 13'h0080, 8'hA5}, '{1'b0, E, 13'h1180, 8'h3C}, '{1'b0, S, 13'h1180, 8'hA5},
    '{1'b0, E, 13'h01FF, 8'h5A}, '{1'b1, E, 13'h1280, 8'h77}, '{1'b0, E, 13'h1280, 8'h00},
    '{1'b0, E, 13'h1180, 8'h3C}, '{1'b1, E, 13'h0400, 8'hC3}, '{1'b1, E, 13'h041F, 8'h81},
    '{1'b0, E, 13'h0400, 8'hC3}, '{1'b0, E, 13'h0420, 8'h00}, '{1'b0, E, 13'h0500, 8'h00},
    '{1'b1, S, 13'h0003, 8'h80}, '{1'b1, S, 13'h0004, 8'h11}, '{1'b0, S, 13'h0002, 8'h3C},
    '{1'b1, S, 13'h0002, 8'h99}, '{1'b0, E, 13'h1180, 8'h99}, '{1'b1, S, 13'h000D, 8'hFF},
    '{1'b1, S, 13'h000E, 8'h01}, '{1'b0, S, 13'h000C, 8'h5A}, '{1'b0, S, 13'h0003, 8'h80},
    '{1'b1, S, 13'h000E, 8'h21}, '{1'b0, S, 13'h000C, 8'h00}, '{1'b1, S, 13'h0020, 8'h44},
    '{1'b0, S, 13'h0020, 8'h44}, '{1'b1, S, 13'h0060, 8'h11}, '{1'b0, S, 13'h0060, 8'hA6},
    '{1'b0, S, 13'h0070, 8'h00}, '{1'b1, E, 13'h0130, 8'h55}, '{1'b0, E, 13'h0130, 8'h55},
    '{1'b0, E, 13'h0120, 8'hA6}, '{1'b0, S, 13'h0120, 8'h44}, '{1'b1, S, 13'h000E, 8'h00},
    '{1'b1, S, 13'h000D, 8'hC5}, '{1'b1, S, 13'h000C, 8'h3E}, '{1'b0, E, 13'h00C5, 8'h3E},
    '{1'b1, E, 13'h08C0, 8'h6E}, '{1'b0, E, 13'h08C0, 8'h6E}};

  dms_decoder dut (.clk_sys(clk_sys), .nrst(nrst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqMode(reqMode), .reqOp(reqOp), .reqBit(reqBit), .reqAddr(reqAddr),
    .reqWrData(reqWrData), .programBankSelect(programBankSelect), .rdData(rdData),
    .rdValid(rdValid), .lcdSegData(lcdSegData), .sfrWrData(sfrWrData), .sfrAddr(sfrAddr),
    .sfrSector(sfrSector), .sfrWrite(sfrWrite), .sfrRdData(sfrRdData),
    .sfrImplemented(sfrImplemented), .sfrProtected(sfrProtected));
  dms_sfr_model sfr (.clk_sys(clk_sys), .sfrWrData(sfrWrData), .sfrAddr(sfrAddr),
    .sfrSector(sfrSector), .sfrWrite(sfrWrite), .sfrRdData(sfrRdData),
    .sfrImplemented(sfrImplemented), .sfrProtected(sfrProtected));

  always #5 clk_sys = ~clk_sys;

  task automatic print_verdict;
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // drives one request at a falling edge; after a bit operation the next call must wait one idle cycle
  task automatic go(input dms_row_t r, input dms_op_t op, input logic [2:0] b);
    reqValid = 1'b1;
    reqWrite = r.w;
    reqMode = r.m;
    reqOp = op;
    reqBit = b;
    reqAddr = r.a;
    reqWrData = r.d;
    @(negedge clk_sys);
    chk8({7'h00, rdValid}, {7'h00, ~r.w});
    if (!r.w) begin
      chk8(rdData, r.d);
    end
  endtask

  task automatic idle;
    reqValid = 1'b0;
    @(negedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    chk8(rdData, 8'h00);
    chk8({7'h00, rdValid}, 8'h00);
    chk8({7'h00, lcdSegData === '0}, 8'h01);
    go('{1'b0, S, 13'h000D, 8'h00}, DMS_OP_BYTE, 3'h0);
    for (int i = 0; i < NR; i++) begin
      programBankSelect = 8'(i) ^ 8'hA5;
      go(rows[i], DMS_OP_BYTE, 3'h0);
    end
    chk8(lcdSegData[7:0], 8'hC3);
    chk8(lcdSegData[255:248], 8'h81);
    go('{1'b1, E, 13'h0081, 8'h01}, DMS_OP_BYTE, 3'h0);
    go('{1'b1, E, 13'h0081, 8'h00}, DMS_OP_BSET, 3'h7);
    idle();
    go('{1'b0, E, 13'h0081, 8'h81}, DMS_OP_BYTE, 3'h0);
    go('{1'b1, E, 13'h0081, 8'hFF}, DMS_OP_BCLR, 3'h0);
    idle();
    go('{1'b0, E, 13'h0081, 8'h80}, DMS_OP_BYTE, 3'h0);
    go('{1'b1, S, 13'h0021, 8'h00}, DMS_OP_BSET, 3'h0);
    idle();
    go('{1'b0, S, 13'h0021, 8'hA7}, DMS_OP_BYTE, 3'h0);
    go('{1'b1, S, 13'h0061, 8'h00}, DMS_OP_BCLR, 3'h1);
    idle();
    go('{1'b0, S, 13'h0061, 8'hA6}, DMS_OP_BYTE, 3'h0);
    idle();
    go('{1'b1, E, 13'h041F, 8'h00}, DMS_OP_BCLR, 3'h7);
    idle();
    chk8(lcdSegData[255:248], 8'h01);
    go('{1'b0, E, 13'h041F, 8'h01}, DMS_OP_BYTE, 3'h0);
    go('{1'b1, S, 13'h0003, 8'h00}, DMS_OP_BSET, 3'h0);
    idle();
    go('{1'b0, S, 13'h0003, 8'h81}, DMS_OP_BYTE, 3'h0);
    idle();
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    chk8({7'h00, lcdSegData === '0}, 8'h01);
    go('{1'b0, S, 13'h0003, 8'h00}, DMS_OP_BYTE, 3'h0);
    go('{1'b0, E, 13'h1180, 8'h99}, DMS_OP_BYTE, 3'h0);
    idle();
    print_verdict();
  end
endmodule
